// ---- hdl/flrcmd_map.vh ----
// Opcodes, parameter-table header bytes and sizes for the lock/reset/param command slice.
// Included by the command interpreter only.
`ifndef FLRCMD_MAP_VH
`define FLRCMD_MAP_VH
`define FLRCMD_OP_LOCK_STATUS  8'h3c
`define FLRCMD_OP_LOCK_ALL     8'h7e
`define FLRCMD_OP_UNLOCK_ALL   8'h98
`define FLRCMD_OP_RDYBSY_EN    8'h70
`define FLRCMD_OP_RDYBSY_DIS   8'h80
`define FLRCMD_OP_NOP          8'h00
`define FLRCMD_OP_RESET_ARM    8'h66
`define FLRCMD_OP_RESET        8'h99
`define FLRCMD_OP_PARAM_READ   8'h5a
`define FLRCMD_OP_WRITE_EN     8'h06
`define FLRCMD_OP_WRITE_DIS    8'h04
`define FLRCMD_ADDR_BYTES      3
`define FLRCMD_DUMMY_BYTES     1
`define FLRCMD_SIG_B0          8'h53
`define FLRCMD_SIG_B1          8'h46
`define FLRCMD_SIG_B2          8'h44
`define FLRCMD_SIG_B3          8'h50
`define FLRCMD_REV_MINOR       8'h00
`define FLRCMD_REV_MAJOR       8'h01
`define FLRCMD_HDR_COUNT       8'h01
`define FLRCMD_HDR0_ID         8'h00
`define FLRCMD_HDR0_LEN        8'h09
`define FLRCMD_HDR0_PTR        8'h30
`define FLRCMD_HDR1_LEN        8'h04
`define FLRCMD_HDR1_PTR        8'h60
`define FLRCMD_UNUSED_BYTE     8'hff
`define FLRCMD_UNITS_LOG2      12
`endif

// ---- hdl/flrcmd_core.v ----
// Serial command interpreter: lock status, whole-chip lock/unlock, ready/busy on
// the serial output, no-operation, two-step reset and parameter-table read.
// Assumes chip select, serial clock and serial input come from an outside host
// and are sampled here on core_clk_i; serial clock must be well below core rate.
// Contract
// RULE_01: lock status read needs protection mode
// RULE_02: 3Ch plus three address bytes, status out
// RULE_03: unit chosen from A23-A16 or A23-A12
// RULE_04: first output byte: 1 locked, 0 open
// RULE_05: 7Eh locks all, 98h unlocks all
// RULE_06: host sends write enable before lock/unlock
// RULE_07: these commands need exact byte boundary
// RULE_08: ready/busy enable drives it in continuous programming
// RULE_09: ready/busy disable stops that output
// RULE_10: no-operation only cancels pending reset arm
// RULE_11: reset only directly after reset arm
// RULE_12: reset restores every volatile default
// RULE_13: reset aborts running program or erase
// RULE_14: host waits longer after aborted program
// RULE_15: 5Ah, three address, one dummy, stream table
// RULE_16: chip select high stops output at once
// RULE_17: table starts with signature, low byte first
// RULE_18: header count zero based, revision 1.0
// RULE_19: first header id 00h, 09h, 30h
// RULE_20: second header maker id, 04h, 60h, FFh
// RULE_21: lock bits all set at power-up
// RULE_22: write-protect low protects all units
// RULE_23: without protection mode lock commands ignored
// RULE_24: status and table reads keep write enable
`include "flrcmd_map.vh"
module flrcmd_core #(
	parameter [7:0] MAKER_ID = 8'h5e // Arbitrary neutral maker code
) (
	input  wire        core_clk_i,
	input  wire        arst_n_i,
	input  wire        cs_n_i,
	input  wire        sclk_i,
	input  wire        sdi_i,
	input  wire        wp_n_i,
	input  wire        per_block_protect_select_i,
	input  wire        sector_mode_i,
	input  wire        continuous_program_mode_i,
	input  wire        busy_i,
	input  wire        program_active_i,
	output reg         sdo_o,
	output reg         sdo_oe_o,
	output reg         write_enable_o,
	output reg         rdybsy_out_en_o,
	output reg         op_abort_o,
	output reg         abort_was_program_o,
	output reg         soft_reset_o,
	output wire        all_protected_o
);
	localparam ST_OPC  = 3'd0;
	localparam ST_ADDR = 3'd1;
	localparam ST_DUMY = 3'd2;
	localparam ST_OUT  = 3'd3;
	localparam ST_IGN  = 3'd4;
	localparam NUNITS  = 1 << `FLRCMD_UNITS_LOG2;

	reg [2:0]  cs_sync;
	reg [2:0]  clk_sync;
	reg [1:0]  di_sync;
	reg [2:0]  state;
	reg [2:0]  bitcnt;
	reg [7:0]  shreg;
	reg [7:0]  opcode;
	reg [1:0]  bytecnt;
	reg [23:0] addr;
	reg [7:0]  tx;
	reg [7:0]  tbl_addr;
	reg        reset_armed;
	reg        byte_done;
	reg [NUNITS-1:0] lock_bits;
	reg        fall_pending;
	// Set by any bit after the opcode byte of a single-byte frame; such frames never execute
	reg        over_len;
	reg [1:0]  wp_sync;

	wire cs_act   = ~cs_sync[1];
	wire cs_rise  = cs_sync[1] & ~cs_sync[2];
	wire cs_fall  = ~cs_sync[1] & cs_sync[2];
	wire sc_rise  = clk_sync[1] & ~clk_sync[2];
	wire sc_fall  = ~clk_sync[1] & clk_sync[2];
	wire [7:0] rx = {shreg[6:0], di_sync[1]};

	// Sector mode uses the full 12-bit index; block mode strips the sector bits
	wire [`FLRCMD_UNITS_LOG2-1:0] unit_idx = sector_mode_i ? addr[23:12] :
		{addr[23:16], 4'h0}; // RULE_03
	wire unit_locked = lock_bits[unit_idx] | ~wp_sync[1]; // RULE_22

	assign all_protected_o = per_block_protect_select_i & ~wp_sync[1]; // RULE_22

	function [7:0] tbl_byte;
		input [7:0] a;
		input [7:0] maker;
		begin
			case (a)
				8'h00: tbl_byte = `FLRCMD_SIG_B0; // RULE_17
				8'h01: tbl_byte = `FLRCMD_SIG_B1;
				8'h02: tbl_byte = `FLRCMD_SIG_B2;
				8'h03: tbl_byte = `FLRCMD_SIG_B3;
				8'h04: tbl_byte = `FLRCMD_REV_MINOR; // RULE_18
				8'h05: tbl_byte = `FLRCMD_REV_MAJOR;
				8'h06: tbl_byte = `FLRCMD_HDR_COUNT;
				8'h08: tbl_byte = `FLRCMD_HDR0_ID; // RULE_19
				8'h09: tbl_byte = `FLRCMD_REV_MINOR;
				8'h0a: tbl_byte = `FLRCMD_REV_MAJOR;
				8'h0b: tbl_byte = `FLRCMD_HDR0_LEN;
				8'h0c: tbl_byte = `FLRCMD_HDR0_PTR;
				8'h0d: tbl_byte = 8'h00;
				8'h0e: tbl_byte = 8'h00;
				8'h10: tbl_byte = maker; // RULE_20
				8'h11: tbl_byte = `FLRCMD_REV_MINOR;
				8'h12: tbl_byte = `FLRCMD_REV_MAJOR;
				8'h13: tbl_byte = `FLRCMD_HDR1_LEN;
				8'h14: tbl_byte = `FLRCMD_HDR1_PTR;
				8'h15: tbl_byte = 8'h00;
				8'h16: tbl_byte = 8'h00;
				default: tbl_byte = `FLRCMD_UNUSED_BYTE;
			endcase
		end
	endfunction

	wire [7:0] tbl_cur = tbl_byte(tbl_addr, MAKER_ID);

	// Pin inputs pass two flops; the third stage only feeds edge detection
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cs_sync  <= 3'h7;
			clk_sync <= 3'h0;
			di_sync  <= 2'h0;
			wp_sync  <= 2'h3;
		end else begin
			cs_sync  <= {cs_sync[1:0], cs_n_i};
			clk_sync <= {clk_sync[1:0], sclk_i};
			di_sync  <= {di_sync[0], sdi_i};
			wp_sync  <= {wp_sync[0], wp_n_i};
		end
	end

	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state               <= ST_OPC;
			bitcnt              <= 3'h0;
			shreg               <= 8'h00;
			opcode              <= 8'h00;
			bytecnt             <= 2'h0;
			addr                <= 24'h000000;
			tx                  <= 8'h00;
			tbl_addr            <= 8'h00;
			reset_armed         <= 1'b0;
			byte_done           <= 1'b0;
			lock_bits           <= {NUNITS{1'b1}};
			write_enable_o      <= 1'b0;
			rdybsy_out_en_o     <= 1'b0;
			op_abort_o          <= 1'b0;
			abort_was_program_o <= 1'b0;
			soft_reset_o        <= 1'b0;
			sdo_o               <= 1'b0;
			sdo_oe_o            <= 1'b0;
			fall_pending        <= 1'b0;
			over_len            <= 1'b0;
		end else begin
			op_abort_o   <= 1'b0;
			soft_reset_o <= 1'b0;
			if (cs_fall) begin
				state     <= ST_OPC;
				bitcnt    <= 3'h0;
				byte_done <= 1'b0;
				over_len  <= 1'b0;
			end
			if (cs_act && sc_rise && state == ST_IGN)
				over_len <= 1'b1; // RULE_07
			if (!cs_act) begin
				sdo_oe_o <= 1'b0; // RULE_16
				sdo_o    <= 1'b0;
			end else if (state != ST_OUT && continuous_program_mode_i && rdybsy_out_en_o) begin
				sdo_oe_o <= 1'b1; // RULE_08
				sdo_o    <= ~busy_i;
			end else if (state != ST_OUT) begin
				sdo_oe_o <= 1'b0; // RULE_09
			end
			if (cs_act && sc_rise && state != ST_OUT && state != ST_IGN) begin
				shreg     <= rx;
				bitcnt    <= bitcnt + 3'd1;
				byte_done <= (bitcnt == 3'd7);
				if (bitcnt == 3'd7) begin
					case (state)
						ST_OPC: begin
							opcode  <= rx;
							bytecnt <= 2'h0;
							// Any opcode but reset voids the armed reset
							if (rx != `FLRCMD_OP_RESET)
								reset_armed <= 1'b0; // RULE_10 RULE_11
							if (rx == `FLRCMD_OP_PARAM_READ ||
								(rx == `FLRCMD_OP_LOCK_STATUS &&
								per_block_protect_select_i)) // RULE_01 RULE_23
								state <= ST_ADDR; // RULE_02 RULE_15
							else
								state <= ST_IGN;
						end
						ST_ADDR: begin
							addr    <= {addr[15:0], rx};
							bytecnt <= bytecnt + 2'd1;
							if (bytecnt == 2'd2) begin
								if (opcode == `FLRCMD_OP_PARAM_READ) begin
									state <= ST_DUMY;
								end else begin
									state <= ST_OUT;
									fall_pending <= 1'b1;
								end
							end
						end
						ST_DUMY: begin
							state        <= ST_OUT;
							tbl_addr     <= addr[7:0];
							fall_pending <= 1'b1;
						end
						default: state <= ST_IGN;
					endcase
				end
			end
			// Output setup on the first falling edge after the last input bit
			if (cs_act && sc_fall && state == ST_OUT) begin
				sdo_oe_o <= 1'b1;
				if (fall_pending) begin
					fall_pending <= 1'b0;
					bitcnt       <= 3'h1;
					if (opcode == `FLRCMD_OP_PARAM_READ) begin
						tx       <= tbl_cur; // RULE_17
						sdo_o    <= tbl_cur[7];
						tbl_addr <= tbl_addr + 8'd1;
					end else begin
						tx    <= {7'h00, unit_locked}; // RULE_04
						sdo_o <= 1'b0;
					end
				end else begin
					bitcnt <= bitcnt + 3'd1;
					if (bitcnt == 3'd0) begin
						if (opcode == `FLRCMD_OP_PARAM_READ) begin
							tx       <= tbl_cur;
							sdo_o    <= tbl_cur[7];
							tbl_addr <= tbl_addr + 8'd1;
						end else begin
							// Status repeats in every byte until chip select rises
							tx    <= {7'h00, unit_locked};
							sdo_o <= 1'b0;
						end
					end else begin
						sdo_o <= tx[~bitcnt];
					end
				end
			end
			// Single-byte commands execute at chip select rise on a byte boundary
			if (cs_rise && state == ST_IGN && byte_done && !over_len) begin // RULE_07
				case (opcode)
					`FLRCMD_OP_WRITE_EN:  write_enable_o <= 1'b1;
					`FLRCMD_OP_WRITE_DIS: write_enable_o <= 1'b0;
					`FLRCMD_OP_LOCK_ALL: begin
						if (per_block_protect_select_i && write_enable_o) begin // RULE_05 RULE_06
							lock_bits      <= {NUNITS{1'b1}};
							write_enable_o <= 1'b0;
						end
					end
					`FLRCMD_OP_UNLOCK_ALL: begin
						if (per_block_protect_select_i && write_enable_o) begin // RULE_05 RULE_23
							lock_bits      <= {NUNITS{1'b0}};
							write_enable_o <= 1'b0;
						end
					end
					`FLRCMD_OP_RDYBSY_EN:  rdybsy_out_en_o <= 1'b1; // RULE_08
					`FLRCMD_OP_RDYBSY_DIS: rdybsy_out_en_o <= 1'b0; // RULE_09
					`FLRCMD_OP_RESET_ARM:  reset_armed <= 1'b1; // RULE_11
					`FLRCMD_OP_RESET: begin
						if (reset_armed) begin // RULE_11
							// Volatile state back to power-on values
							lock_bits           <= {NUNITS{1'b1}}; // RULE_12 RULE_21
							write_enable_o      <= 1'b0;
							rdybsy_out_en_o     <= 1'b0;
							op_abort_o          <= busy_i; // RULE_13
							abort_was_program_o <= busy_i & program_active_i; // RULE_14
							soft_reset_o        <= 1'b1;
						end
						reset_armed <= 1'b0;
					end
					default: ;
				endcase
			end
			if (cs_rise) begin
				state        <= ST_OPC; // RULE_24
				fall_pending <= 1'b0;
				bitcnt       <= 3'h0;
			end
		end
	end
endmodule // flrcmd_core

// ---- verification/flrcmd_props.sv ----
// Checker for flrcmd_core, bound below.
// Assumes chip select idles high for several core cycles between frames.
module flrcmd_props (
	input wire core_clk_i,
	input wire arst_n_i,
	input wire cs_n_i,
	input wire wp_n_i,
	input wire per_block_protect_select_i,
	input wire busy_i,
	input wire program_active_i,
	input wire sdo_oe_o,
	input wire write_enable_o,
	input wire rdybsy_out_en_o,
	input wire op_abort_o,
	input wire abort_was_program_o,
	input wire soft_reset_o,
	input wire all_protected_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!arst_n_i);
	// State moves only after the pin rise has passed the synchroniser
	sequence s_cs_risen;
		$past(cs_n_i, 2) && $past(cs_n_i);
	endsequence
	sequence s_cs_idle;
		cs_n_i [*4];
	endsequence
	a_prot_all: assert property (all_protected_o == (per_block_protect_select_i && !$past(wp_n_i, 2)))
		else $error("protect-all flag wrong");
	a_oe_release: assert property (s_cs_idle |-> !sdo_oe_o)
		else $error("output driven after deselect");
	a_wen_edge: assert property ($changed(write_enable_o) |-> s_cs_risen)
		else $error("write enable moved inside a frame");
	a_rdy_edge: assert property ($changed(rdybsy_out_en_o) |-> s_cs_risen)
		else $error("ready/busy enable moved inside a frame");
	a_rst_edge: assert property (soft_reset_o |-> s_cs_risen)
		else $error("reset not at frame end");
	a_rst_clear: assert property (soft_reset_o |-> ##[0:2] (!write_enable_o && !rdybsy_out_en_o))
		else $error("reset left settings");
	a_rst_pulse: assert property (soft_reset_o |=> !soft_reset_o)
		else $error("reset pulse too long");
	a_abort_busy: assert property (op_abort_o |-> busy_i)
		else $error("abort while idle");
	a_abort_prog: assert property (op_abort_o && program_active_i |-> ##[0:1] abort_was_program_o)
		else $error("program abort not flagged");
endmodule // flrcmd_props

bind flrcmd_core flrcmd_props chk_u (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
	.cs_n_i(cs_n_i), .wp_n_i(wp_n_i), .per_block_protect_select_i(per_block_protect_select_i),
	.busy_i(busy_i), .program_active_i(program_active_i), .sdo_oe_o(sdo_oe_o),
	.write_enable_o(write_enable_o), .rdybsy_out_en_o(rdybsy_out_en_o),
	.op_abort_o(op_abort_o), .abort_was_program_o(abort_was_program_o),
	.soft_reset_o(soft_reset_o), .all_protected_o(all_protected_o));

// ---- verification/flrcmd_host.sv ----
// Serial host model: mode 0 frames, 125 ns serial clock.
// Assumes one frame at a time; clock stands low between frames.
module flrcmd_host (
	output logic sclk_o,
	output logic cs_n_o,
	output logic sdi_o,
	input  wire  sdo_i,
	input  wire  sdo_oe_i
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] rx [$];
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
	end
	// Undriven output reads as unknown; sdi toggles once its bits are sent
	task automatic xfer(input logic [39:0] tx, input int nbits, input int nrd);
		logic [7:0] b;
		rx = {};
		cs_n_o = 1'b0;
		#62.5;
		for (int i = 0; i < nbits + 8 * nrd; i++) begin
			sdi_o = (i < nbits) ? tx[nbits - 1 - i] : ~sdi_o;
			#62.5 sclk_o = 1'b1;
			if (i >= nbits) begin
				b = {b[6:0], sdo_oe_i ? sdo_i : 1'bx};
				if ((i - nbits) % 8 == 7) rx.push_back(b);
			end
			#62.5 sclk_o = 1'b0;
		end
		#62.5 cs_n_o = 1'b1;
		#250;
	endtask
endmodule // flrcmd_host

// ---- verification/tb_top.sv ----
// Self-checking bench for flrcmd_core behind the serial host model.
// Assumes the checker is bound in; static inputs move only between frames.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] MAKER = 8'h5e; // Arbitrary maker code
	localparam logic [191:0] HDR = {32'h53464450, 32'h000101ff, 32'h00000109,
		32'h300000ff, MAKER, 24'h000104, 32'h600000ff};
	logic core_clk_i = 1'b0, arst_n_i = 1'b0, wp_n = 1'b1, prot = 1'b0, sect = 1'b0;
	logic cpm = 1'b0, busy = 1'b0, prog = 1'b0;
	logic [31:0] seed = 32'ha8dc;
	wire cs_n, sclk, sdi, sdo, sdo_oe, wen, rdy_en, abort, abort_prog, srst, all_prot;
	int fail_count = 0, n_tests = 0, n_srst = 0, n_abort = 0;
	always #5 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		if (srst === 1'b1) n_srst++;
		if (abort === 1'b1) n_abort++;
	end
	flrcmd_host host_u (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_i(sdo_oe));
	flrcmd_core #(.MAKER_ID(MAKER)) dut_u (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
		.cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .wp_n_i(wp_n),
		.per_block_protect_select_i(prot), .sector_mode_i(sect),
		.continuous_program_mode_i(cpm), .busy_i(busy), .program_active_i(prog),
		.sdo_o(sdo), .sdo_oe_o(sdo_oe), .write_enable_o(wen), .rdybsy_out_en_o(rdy_en),
		.op_abort_o(abort), .abort_was_program_o(abort_prog), .soft_reset_o(srst),
		.all_protected_o(all_prot));
	function automatic logic [31:0] rnd(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// Header bytes beyond the two headers read as erased
	function automatic logic [7:0] exp_tbl(input logic [7:0] a);
		return (a < 8'h18) ? HDR[191 - 8 * a -: 8] : 8'hff;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick;
		@(posedge core_clk_i);
		#1;
	endtask
	task automatic cmd(input logic [7:0] op);
		host_u.xfer({32'h0, op}, 8, 0);
	endtask
	// Status repeats each byte, so both bytes are compared
	task automatic stat(input logic [7:0] exp);
		seed = rnd(seed);
		host_u.xfer({8'h3c, seed[23:0]}, 32, 2);
		chk(host_u.rx[0], exp);
		chk(host_u.rx[1], exp);
	endtask
	task automatic final_report;
		$display("Checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#400us;
		fail_count++;
		final_report();
	end
	initial begin
		logic [7:0] a;
		int n;
		repeat (10) @(posedge core_clk_i);
		#1 arst_n_i = 1'b1;
		repeat (3) tick();
		chk({4'h0, wen, rdy_en, abort_prog, srst}, 8'h00);
		host_u.xfer({8'h5a, 32'h0}, 40, 24);
		for (int i = 0; i < 24; i++) chk(host_u.rx[i], exp_tbl(8'(i)));
		for (int k = 0; k < 5; k++) begin
			seed = rnd(seed);
			a = seed[7] ? 8'hfe : {3'h0, seed[4:0]};
			n = 1 + seed[10:8];
			host_u.xfer({8'h5a, 16'h0, a, 8'h0}, 40, n);
			for (int i = 0; i < n; i++) chk(host_u.rx[i], exp_tbl(a + 8'(i)));
		end
		$display("Test table done");
		host_u.xfer({8'h0, 8'h3c, seed[23:0]}, 32, 1);
		chk(host_u.rx[0], 8'hxx);
		cmd(8'h06);
		cmd(8'h98);
		chk({7'h0, wen}, 8'h01);
		tick();
		prot = 1'b1;
		stat(8'h01);
		chk({7'h0, wen}, 8'h01);
		host_u.xfer({31'h0, 8'h98, 1'b0}, 9, 0);
		chk({7'h0, wen}, 8'h01);
		cmd(8'h98);
		chk({7'h0, wen}, 8'h00);
		stat(8'h00);
		cmd(8'h7e);
		stat(8'h00);
		tick();
		sect = 1'b1;
		cmd(8'h06);
		cmd(8'h7e);
		stat(8'h01);
		tick();
		wp_n = 1'b0;
		repeat (3) tick();
		chk({7'h0, all_prot}, 8'h01);
		wp_n = 1'b1;
		cmd(8'h06);
		cmd(8'h98);
		$display("Test locks done");
		tick();
		cpm = 1'b1;
		cmd(8'h70);
		chk({7'h0, rdy_en}, 8'h01);
		for (int b = 0; b < 2; b++) begin
			tick();
			busy = b[0];
			host_u.xfer({32'h0, 8'h00}, 8, 1);
			chk(host_u.rx[0], {8{~busy}});
		end
		tick();
		busy = 1'b0;
		host_u.xfer({24'h0, 8'h80, 8'h00}, 16, 0);
		chk({7'h0, rdy_en}, 8'h01);
		cmd(8'h80);
		host_u.xfer({32'h0, 8'h00}, 8, 1);
		chk({7'h0, rdy_en}, 8'h00);
		chk(host_u.rx[0], 8'hxx);
		cmd(8'h70);
		cmd(8'h66);
		cmd(8'h00);
		cmd(8'h99);
		chk(8'(n_srst), 8'h00);
		chk({7'h0, rdy_en}, 8'h01);
		tick();
		busy = 1'b1;
		prog = 1'b1;
		cmd(8'h66);
		cmd(8'h99);
		chk({6'h0, n_srst[0], n_abort[0]}, 8'h03);
		chk({6'h0, abort_prog, rdy_en}, 8'h02);
		busy = 1'b0;
		#2us;
		stat(8'h01);
		$display("Test reset done");
		final_report();
	end
endmodule // tb_top
